/* src/ext_mem_iface.sv */
// Contract
// - Config bit mux_select_bit picks multiplexed (0) or separate address/data pins (1).
// - In multiplexed mode the low address byte and data share the eight ad pins.
// - In multiplexed mode this block drives the address-latch strobe for the external latch.
// - A multiplexed access opens with strobe high and the low address byte on the ad pins.
// - The strobe falling edge starts phase two; the latch holds from then on.
// - Later in phase two the ad pins carry data while read or write strobe is low.
//
`timescale 1ns/1ps
`default_nettype none
`include "ext_mem_regs.svh"

module ext_mem_iface #(
    parameter int ADDR_WIDTH = 16,
    parameter int DATA_WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic nrst,
    // Core special-function-register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Core external move request
    input wire logic xreq,
    input wire logic xwe,
    input wire logic [ADDR_WIDTH-1:0] xaddr,
    input wire logic [DATA_WIDTH-1:0] xwdata,
    output logic [DATA_WIDTH-1:0] xrdata,
    output logic xdone,
    output logic xbusy,
    // Configuration fields seen by the core's address decode
    output logic [1:0] memory_map_mode,
    output logic usb_fifo_window_enable,
    // External memory pins
    output logic [ADDR_WIDTH-9:0] addr_hi_out,
    output logic [7:0] addr_lo_out,
    output logic [DATA_WIDTH-1:0] ad_out,
    input wire logic [DATA_WIDTH-1:0] ad_in,
    output logic ad_oe,
    output logic ale,
    output logic rd_n,
    output logic wr_n
);

    localparam logic [2:0] STROBE_LOAD = 3'(`RW_STROBE_CYCLES - 1);

    // Timer reload for a strobe phase of (field + 1) cycles
    function automatic logic [2:0] strobe_load(input logic [1:0] width_field);
        strobe_load = {1'b0, width_field};
    endfunction : strobe_load

    // ----------------------------------------------------------------
    // Configuration register
    // ----------------------------------------------------------------
    logic [7:0] ext_mem_config;
    logic [7:0] next_ext_mem_config;
    logic [7:0] next_sfr_rdata;
    logic cfg_hit;

    assign cfg_hit = (sfr_addr == `EXT_MEM_CONFIG_ADDR);

    // Unused bits are never stored, so they read back as zero
    always_comb begin
        next_ext_mem_config = ext_mem_config;
        next_sfr_rdata = `SFR_READ_IDLE;
        if (sfr_wr && cfg_hit) begin
            next_ext_mem_config = sfr_wdata & `EXT_MEM_CONFIG_MASK;
        end
        if (sfr_rd && cfg_hit) begin
            next_sfr_rdata = ext_mem_config;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ext_mem_config <= `EXT_MEM_CONFIG_RESET;
            sfr_rdata <= `SFR_READ_IDLE;
            memory_map_mode <= 2'h0;
            usb_fifo_window_enable <= 1'b0;
        end else begin
            ext_mem_config <= next_ext_mem_config;
            sfr_rdata <= next_sfr_rdata;
            memory_map_mode <= next_ext_mem_config[`MEMORY_MAP_MODE_MSB:`MEMORY_MAP_MODE_LSB];
            usb_fifo_window_enable <= next_ext_mem_config[`USB_FIFO_WINDOW_ENABLE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Phase timer
    // ----------------------------------------------------------------
    logic timer_load;
    logic [2:0] timer_value;
    logic [2:0] timer_count;

    phase_timer #(
        .WIDTH(3)
    ) u_phase_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .load(timer_load),
        .load_value(timer_value),
        .count(timer_count)
    );

    // ----------------------------------------------------------------
    // Access sequencer
    // ----------------------------------------------------------------
    ext_mem_pkg::access_state_t state;
    ext_mem_pkg::access_state_t next_state;
    logic we_q;
    logic next_we_q;
    logic [1:0] width_q;
    logic [1:0] next_width_q;
    logic [DATA_WIDTH-1:0] wdata_q;
    logic [DATA_WIDTH-1:0] next_wdata_q;
    logic [DATA_WIDTH-1:0] next_xrdata;
    logic next_xdone;
    logic next_xbusy;
    logic [ADDR_WIDTH-9:0] next_addr_hi_out;
    logic [7:0] next_addr_lo_out;
    logic [DATA_WIDTH-1:0] next_ad_out;
    logic next_ad_oe;
    logic next_ale;
    logic next_rd_n;
    logic next_wr_n;
    logic phase_end;

    assign phase_end = (timer_count == 3'h0);

    // Mode and width are sampled per access so a config write
    // mid-cycle cannot tear a strobe sequence apart
    always_comb begin
        next_state = state;
        next_we_q = we_q;
        next_width_q = width_q;
        next_wdata_q = wdata_q;
        next_xrdata = xrdata;
        next_xdone = 1'b0;
        next_xbusy = xbusy;
        next_addr_hi_out = addr_hi_out;
        next_addr_lo_out = addr_lo_out;
        next_ad_out = ad_out;
        next_ad_oe = ad_oe;
        next_ale = ale;
        next_rd_n = rd_n;
        next_wr_n = wr_n;
        timer_load = 1'b0;
        timer_value = 3'h0;
        unique case (state)
            ext_mem_pkg::ST_IDLE: begin
                if (xreq) begin
                    next_we_q = xwe;
                    next_width_q =
                        ext_mem_config[`LATCH_STROBE_WIDTH_MSB:`LATCH_STROBE_WIDTH_LSB];
                    next_wdata_q = xwdata;
                    next_xbusy = 1'b1;
                    next_addr_hi_out = xaddr[ADDR_WIDTH-1:8];
                    next_addr_lo_out = xaddr[7:0];
                    timer_load = 1'b1;
                    if (!ext_mem_config[`MUX_SELECT_BIT]) begin
                        // Low address on shared pins, latch open
                        next_state = ext_mem_pkg::ST_ALE_HIGH;
                        next_ale = 1'b1;
                        next_ad_out = DATA_WIDTH'(xaddr[7:0]);
                        next_ad_oe = 1'b1;
                        timer_value = strobe_load(
                            ext_mem_config[`LATCH_STROBE_WIDTH_MSB:`LATCH_STROBE_WIDTH_LSB]);
                    end else begin
                        // Separate pins: go straight to the data strobe
                        next_state = ext_mem_pkg::ST_STROBE;
                        next_ad_out = xwdata;
                        next_ad_oe = xwe;
                        next_rd_n = xwe;
                        next_wr_n = ~xwe;
                        timer_value = STROBE_LOAD;
                    end
                end
            end
            ext_mem_pkg::ST_ALE_HIGH: begin
                if (phase_end) begin
                    // Falling strobe freezes the latch; address still held
                    next_state = ext_mem_pkg::ST_ALE_LOW;
                    next_ale = 1'b0;
                    timer_load = 1'b1;
                    timer_value = strobe_load(width_q);
                end
            end
            ext_mem_pkg::ST_ALE_LOW: begin
                if (phase_end) begin
                    // Hand the shared pins over to the data bus
                    next_state = ext_mem_pkg::ST_STROBE;
                    next_ad_out = wdata_q;
                    next_ad_oe = we_q;
                    next_rd_n = we_q;
                    next_wr_n = ~we_q;
                    timer_load = 1'b1;
                    timer_value = STROBE_LOAD;
                end
            end
            ext_mem_pkg::ST_STROBE: begin
                if (phase_end) begin
                    // Read data sampled on the edge that releases the strobe
                    next_state = ext_mem_pkg::ST_RECOVER;
                    next_rd_n = 1'b1;
                    next_wr_n = 1'b1;
                    if (!we_q) begin
                        next_xrdata = ad_in;
                    end
                end
            end
            ext_mem_pkg::ST_RECOVER: begin
                // Write data held one cycle past the strobe for hold time
                next_state = ext_mem_pkg::ST_IDLE;
                next_ad_oe = 1'b0;
                next_xdone = 1'b1;
                next_xbusy = 1'b0;
            end
            default: begin
                // Unused codes of the state register fall back to idle
                next_state = ext_mem_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ext_mem_pkg::ST_IDLE;
            we_q <= 1'b0;
            width_q <= 2'h0;
            wdata_q <= '0;
            xrdata <= '0;
            xdone <= 1'b0;
            xbusy <= 1'b0;
            addr_hi_out <= '0;
            addr_lo_out <= 8'h00;
            ad_out <= '0;
            ad_oe <= 1'b0;
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
        end else begin
            state <= next_state;
            we_q <= next_we_q;
            width_q <= next_width_q;
            wdata_q <= next_wdata_q;
            xrdata <= next_xrdata;
            xdone <= next_xdone;
            xbusy <= next_xbusy;
            addr_hi_out <= next_addr_hi_out;
            addr_lo_out <= next_addr_lo_out;
            ad_out <= next_ad_out;
            ad_oe <= next_ad_oe;
            ale <= next_ale;
            rd_n <= next_rd_n;
            wr_n <= next_wr_n;
        end
    end

endmodule : ext_mem_iface

`default_nettype wire

/* include/ext_mem_regs.svh */
`ifndef EXT_MEM_REGS_SVH
`define EXT_MEM_REGS_SVH

// ----------------------------------------------------------------
// Configuration register location and layout
// ----------------------------------------------------------------
`define EXT_MEM_CONFIG_ADDR 8'h85
`define EXT_MEM_CONFIG_RESET 8'h03
`define EXT_MEM_CONFIG_MASK 8'h5F
`define USB_FIFO_WINDOW_ENABLE_BIT 6
`define MUX_SELECT_BIT 4
`define MEMORY_MAP_MODE_LSB 2
`define MEMORY_MAP_MODE_MSB 3
`define LATCH_STROBE_WIDTH_LSB 0
`define LATCH_STROBE_WIDTH_MSB 1
`define SFR_READ_IDLE 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SYS_CLK_PERIOD_NS 25
`define RW_STROBE_NS 50
`define RW_STROBE_CYCLES ((`RW_STROBE_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

`endif

/* include/ext_mem_pkg.sv */
package ext_mem_pkg;

    // Access sequencer phases
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ALE_HIGH,
        ST_ALE_LOW,
        ST_STROBE,
        ST_RECOVER
    } access_state_t;

endpackage : ext_mem_pkg

/* src/phase_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module phase_timer #(
    parameter int WIDTH = 3
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic [WIDTH-1:0] count
);

    logic [WIDTH-1:0] next_count;

    // Down counter, reloaded at the start of each timed phase (latch high, latch low, strobe)
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_value;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule : phase_timer

`default_nettype wire

/* test/ext_mem_iface_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Pin timing and SFR read checks
// ----------------------------------------
module ext_mem_iface_checker (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic xreq,
    input wire logic xbusy,
    input wire logic [15:0] xaddr,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n
);
    logic [7:0] cfg;
    logic [2:0] hi_cnt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Config shadow, so mode and width are known without peeking inside
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) cfg <= 8'h03;
        else if (sfr_wr && sfr_addr == 8'h85) cfg <= sfr_wdata;
    end
    // Strobe high time in cycles
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) hi_cnt <= 3'h0;
        else hi_cnt <= ale ? hi_cnt + 3'h1 : 3'h0;
    end
    AST_SFR_MISS: assert property (!(sfr_rd && sfr_addr == 8'h85) |=> sfr_rdata == 8'h00)
        else $error("stray sfr read data");
    AST_MUX_ALE: assert property (!cfg[4] && xreq && !xbusy |=> ale)
        else $error("no latch strobe");
    AST_SEP_NO_ALE: assert property (cfg[4] && xreq && !xbusy |=> !ale [*4])
        else $error("latch strobe in separate mode");
    AST_ALE_ADDR: assert property ($rose(ale) |-> ad_oe && ad_out == $past(xaddr[7:0]))
        else $error("low address not on pins");
    AST_ALE_W: assert property ($fell(ale) |-> hi_cnt == {1'b0, cfg[1:0]} + 3'h1)
        else $error("latch strobe width");
    AST_FELL_LOW: assert property ($fell(ale) |-> !ale [*4])
        else $error("strobe back high in phase two");
    AST_NO_STROBE: assert property (ale |-> rd_n && wr_n)
        else $error("rd or wr during address phase");
    AST_RD_FLOAT: assert property (!rd_n |-> !ad_oe)
        else $error("pins driven during read");
endmodule : ext_mem_iface_checker
bind ext_mem_iface ext_mem_iface_checker ext_mem_iface_checker_i (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sfr_addr(sfr_addr),
    .sfr_rd(sfr_rd),
    .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .xreq(xreq),
    .xbusy(xbusy),
    .xaddr(xaddr),
    .ad_out(ad_out),
    .ad_oe(ad_oe),
    .ale(ale),
    .rd_n(rd_n),
    .wr_n(wr_n)
);
`default_nettype wire

/* test/latch_ram_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// External latch and asynchronous RAM
// ----------------------------------------
module latch_ram_model (
    input wire logic sys_clk,
    input wire logic sep,
    input wire logic [7:0] addr_hi_out,
    input wire logic [7:0] addr_lo_out,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    output logic [7:0] ad_in
);
    logic [7:0] mem [logic [15:0]];
    logic [7:0] q = 8'h00;
    logic [7:0] hold = 8'h00;
    logic [7:0] pat = 8'h5A;
    logic [15:0] a;
    // Transparent while high, frozen from the falling edge
    always @* if (ale) q = ad_out;
    assign a = {addr_hi_out, sep ? addr_lo_out : q};
    // Floating pins toggle each cycle, so stale data cannot pass
    always @(posedge sys_clk) pat <= ~pat;
    always @* ad_in = ad_oe ? ad_out : (!rd_n ? mem[a] : pat);
    // Data taken while write strobe low, stored as it rises
    always @* if (!wr_n) hold = ad_in;
    // The strobe rises out of reset while the address is still unknown
    always @(posedge wr_n) if (!$isunknown(a)) mem[a] = hold;
endmodule : latch_ram_model
`default_nettype wire

/* test/ext_mem_iface_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    $display("[ERR] %0t got %h exp %h", $time, g, e); bad_count++; end end
// ----------------------------------------
// Bench
// ----------------------------------------
module ext_mem_iface_tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic xreq = 1'b0;
    logic xwe = 1'b0;
    logic [15:0] xaddr = 16'h0000;
    logic [7:0] xwdata = 8'h00;
    logic [7:0] sfr_rdata, xrdata, addr_hi_out, addr_lo_out, ad_out, ad_in;
    logic xdone, xbusy, usb_fifo_window_enable, ad_oe, ale, rd_n, wr_n;
    logic [1:0] memory_map_mode;
    logic [7:0] cfg = 8'h03;
    logic [7:0] rm [logic [15:0]];
    logic [31:0] seed = 32'h00014C5A;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    ext_mem_iface ext_mem_iface_i (.*);
    latch_ram_model latch_ram_model_i (.sep(cfg[4]), .*);
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
        if (a == 8'h85) cfg = d & 8'h5F;
        // Let an edge pass so the next strobe is not raised in this step
        @(negedge sys_clk);
    endtask : sfr_w
    task automatic sfr_r(input logic [7:0] a, input logic [7:0] e);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge sys_clk);
        sfr_rd = 1'b0;
        `CHK(sfr_rdata, e)
        @(negedge sys_clk);
    endtask : sfr_r
    // One access; a second request while busy must be ignored
    task automatic xacc(input logic we, input logic [15:0] a, input logic [7:0] d);
        int n;
        int lat;
        n = 0;
        lat = cfg[4] ? 4 : 2 * int'(cfg[1:0]) + 6;
        xwe = we;
        xaddr = a;
        xwdata = d;
        xreq = 1'b1;
        do begin
            @(negedge sys_clk);
            n++;
            xreq = (n == 2);
            xwdata = (n == 2) ? ~d : d;
        end while (n < 20 && xdone !== 1'b1);
        `CHK(n, lat)
        `CHK(addr_hi_out, a[15:8])
        `CHK(addr_lo_out, a[7:0])
        if (we) rm[a] = d;
        else `CHK(xrdata, rm[a])
        @(negedge sys_clk);
    endtask : xacc
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        logic [15:0] a;
        logic [7:0] d;
        repeat (6) @(negedge sys_clk);
        nrst = 1'b1;
        // Reset value, unmapped place, unstored bits
        sfr_r(8'h85, 8'h03);
        sfr_w(8'h84, 8'h10);
        sfr_r(8'h85, 8'h03);
        sfr_r(8'h84, 8'h00);
        sfr_w(8'h85, 8'hFF);
        sfr_r(8'h85, 8'h5F);
        $display("test regs done");
        // Every width in both modes, back to back accesses
        for (int m = 0; m < 8; m++) begin
            seed = xs(seed);
            sfr_w(8'h85, {seed[7:5], m[2], seed[3:2], m[1:0]});
            sfr_r(8'h85, cfg);
            `CHK(memory_map_mode, cfg[3:2])
            `CHK(usb_fifo_window_enable, cfg[6])
            for (int k = 0; k < 4; k++) begin
                seed = xs(seed);
                a = seed[31:16];
                d = seed[7:0];
                xacc(1'b1, a, d);
                xacc(1'b0, a, 8'h00);
            end
            $display("test mode %0d done", m);
        end
        // Second reset brings back the widest strobe
        nrst = 1'b0;
        @(negedge sys_clk);
        nrst = 1'b1;
        cfg = 8'h03;
        sfr_r(8'h85, 8'h03);
        xacc(1'b0, a, 8'h00);
        $display("test reset done");
        tally_and_finish();
    end
endmodule : ext_mem_iface_tb
`default_nettype wire
